// *** logic/sbl_cfg.svh ***
/*
 Constants of the serial boot loader packet protocol: answer codes,
 command codes, packet lengths, status codes and buffer sizes.
 Assumes it is included by bare name wherever the values are needed.
*/
`ifndef SBL_CFG_SVH
`define SBL_CFG_SVH

// Answer codes
`define SBL_ACK 8'hCC
`define SBL_NAK 8'h33

// Command codes
`define SBL_CMD_PING 8'h20
`define SBL_CMD_DOWNLOAD 8'h21
`define SBL_CMD_RUN 8'h22
`define SBL_CMD_QUERY_RESULT 8'h23
`define SBL_CMD_SEND_DATA 8'h24
`define SBL_CMD_RESET 8'h25

// Packet lengths, length and sum bytes included
`define SBL_LEN_SHORT 8'h03
`define SBL_LEN_RUN 8'h07
`define SBL_LEN_DOWNLOAD 8'h0B
`define SBL_LEN_MIN_DATA 8'h04
`define SBL_LEN_MAX 8'h0B

// Status codes held for the status query
`define SBL_ST_SUCCESS 8'h40
`define SBL_ST_UNKNOWN_CMD 8'h41
`define SBL_ST_INVALID_CMD 8'h42

// Receive buffer: command byte plus at most eight data bytes
`define SBL_PAYLOAD_MAX 9
`define SBL_FIFO_DEPTH 8

`endif

// *** logic/sbl_device.sv ***
/*
 Boot loader device end: takes command packets from the link through an
 eight-byte FIFO, answers with ACK or NAK, and drives erase, program,
 run and reset requests to the flash side. Assumes the flash side is on
 the same clock and answers erase and program requests in order.
*/
// Functional notes
// RULE1 - First byte is total packet length
// RULE2 - Second byte is sum of payload only
// RULE3 - Sum kept to eight bits
// RULE4 - Answer each packet with ACK or NAK
// RULE5 - ACK means good reception, not valid command
// RULE6 - Returned packet: zeros, length, sum, payload
// RULE7 - Returned packet bytes sent without gaps
// RULE8 - Host answers returned packet with ACK/NAK
// RULE9 - Host resends command after its NAK
// RULE10 - Skip zeros; first nonzero is host answer
// RULE11 - Host pads zeros to clock out replies
// RULE12 - First payload byte is the command code
// RULE13 - Ping sets status to success
// RULE14 - Status query returns one-byte status packet
// RULE15 - Host queries status after each command; sbl_host sends a query only when the user requests one
// RULE16 - Download parses address then count, MSB first
// RULE17 - Download erases region before ACK
// RULE18 - Send data only after download; address advances
// RULE19 - Host sends at most eight data bytes
// RULE20 - Stop programming when count is reached
// RULE21 - NAK leaves program address unchanged
// RULE22 - Run: ACK first, then jump
// RULE23 - Reset: ACK first, then software reset
`timescale 1ns/10ps
`include "sbl_cfg.svh"
module sbl_device (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   sbl_link_if.dev link,
   output logic erase_req_out,
   output sbl_pkg::sbl_word_t erase_addr_out,
   output sbl_pkg::sbl_word_t erase_size_out,
   input wire logic erase_done_in,
   output logic prog_valid_out,
   output sbl_pkg::sbl_word_t prog_addr_out,
   output sbl_pkg::sbl_byte_t prog_data_out,
   input wire logic prog_ready_in,
   output logic run_out,
   output sbl_pkg::sbl_word_t run_addr_out,
   output logic sw_reset_out,
   output sbl_pkg::sbl_byte_t status_out
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_SUM, ST_PAY, ST_CHECK, ST_ERASE, ST_TX, ST_RESP,
      ST_PROG, ST_ACT
   } sbl_dev_state_t;
   typedef enum logic [2:0] {
      NX_IDLE, NX_RESP, NX_PROG, NX_RUN, NX_RESET
   } sbl_dev_next_t;

   sbl_dev_state_t state_q;
   sbl_dev_next_t next_q;
   sbl_pkg::sbl_byte_t buf_q [`SBL_PAYLOAD_MAX];
   sbl_pkg::sbl_byte_t tx_q [4];
   sbl_pkg::sbl_byte_t len_q;
   sbl_pkg::sbl_byte_t sum_rx_q;
   sbl_pkg::sbl_byte_t sum_acc_q;
   sbl_pkg::sbl_byte_t idx_q;
   sbl_pkg::sbl_byte_t pidx_q;
   logic [1:0] tx_i_q;
   logic [1:0] tx_last_q;
   logic dl_open_q;
   sbl_pkg::sbl_word_t remain_q;
   sbl_pkg::sbl_byte_t d2h_data_q;
   logic d2h_valid_q;

   // FIFO between the link and the parser
   logic rx_valid;
   logic rx_take;
   sbl_pkg::sbl_byte_t rx_data;

   sbl_fifo #(
      .WIDTH(8),
      .DEPTH(`SBL_FIFO_DEPTH)
   ) u_rx_fifo (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(link.h2d_valid),
      .in_data_in(link.h2d_data),
      .in_ready_out(link.h2d_ready),
      .out_valid_out(rx_valid),
      .out_data_out(rx_data),
      .out_ready_in(rx_take)
   );

   // Bytes leave the FIFO only while parsing or awaiting the host answer; erase and
   // programming stall it, so the host sees back-pressure
   assign rx_take = (state_q == ST_IDLE) || (state_q == ST_SUM) ||
                    (state_q == ST_PAY) || (state_q == ST_RESP);
   assign link.d2h_valid = d2h_valid_q;
   assign link.d2h_data = d2h_data_q;

   // Packet decode
   wire sbl_pkg::sbl_byte_t cmd = buf_q[0];
   wire logic rx_byte = rx_valid && rx_take;
   wire logic pkt_good = (sum_acc_q == sum_rx_q) && // RULE2
                         (len_q >= `SBL_LEN_SHORT) &&
                         (len_q <= `SBL_LEN_MAX);
   wire logic data_len_ok = (len_q >= `SBL_LEN_MIN_DATA);
   wire sbl_pkg::sbl_word_t dl_addr = {buf_q[1], buf_q[2], buf_q[3],
                                      buf_q[4]}; // RULE16
   wire sbl_pkg::sbl_word_t dl_size = {buf_q[5], buf_q[6], buf_q[7],
                                      buf_q[8]}; // RULE16
   wire sbl_pkg::sbl_byte_t last_data = len_q - 8'h03;
   wire logic tx_step = d2h_valid_q && link.d2h_ready;
   wire logic prog_step = prog_valid_out && prog_ready_in;
   wire logic prog_end = (pidx_q > last_data) || (remain_q == '0);

   // Expected length of a fixed-size command, zero if variable
   function automatic sbl_pkg::sbl_byte_t fixed_len(
      input sbl_pkg::sbl_byte_t code
   );
      case (code)
         `SBL_CMD_PING, `SBL_CMD_QUERY_RESULT, `SBL_CMD_RESET:
            fixed_len = `SBL_LEN_SHORT;
         `SBL_CMD_RUN: fixed_len = `SBL_LEN_RUN;
         `SBL_CMD_DOWNLOAD: fixed_len = `SBL_LEN_DOWNLOAD;
         default: fixed_len = 8'h00;
      endcase
   endfunction : fixed_len

   wire logic fix_ok = (fixed_len(cmd) == len_q);

   // Receive buffer fills as payload bytes arrive
   always_ff @(posedge core_clk_in) begin
      if (state_q == ST_PAY && rx_byte &&
          idx_q < 8'(`SBL_PAYLOAD_MAX)) begin
         buf_q[idx_q[3:0]] <= rx_data;
      end
   end

   // Packet parser, command execution and answer sender
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_q <= ST_IDLE;
         next_q <= NX_IDLE;
         for (int i = 0; i < 4; i++) begin
            tx_q[i] <= 8'h00;
         end
         len_q <= 8'h00;
         sum_rx_q <= 8'h00;
         sum_acc_q <= 8'h00;
         idx_q <= 8'h00;
         pidx_q <= 8'h00;
         tx_i_q <= 2'd0;
         tx_last_q <= 2'd0;
         dl_open_q <= 1'b0;
         remain_q <= '0;
         d2h_data_q <= 8'h00;
         d2h_valid_q <= 1'b0;
         erase_req_out <= 1'b0;
         erase_addr_out <= '0;
         erase_size_out <= '0;
         prog_valid_out <= 1'b0;
         prog_addr_out <= '0;
         prog_data_out <= 8'h00;
         run_out <= 1'b0;
         run_addr_out <= '0;
         sw_reset_out <= 1'b0;
         status_out <= `SBL_ST_SUCCESS;
      end else begin
         erase_req_out <= 1'b0;
         run_out <= 1'b0;
         sw_reset_out <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (rx_byte && rx_data != 8'h00) begin // RULE1
                  len_q <= rx_data;
                  state_q <= ST_SUM;
               end
            end
            ST_SUM: begin
               if (rx_byte) begin
                  sum_rx_q <= rx_data;
                  sum_acc_q <= 8'h00;
                  idx_q <= 8'h00;
                  state_q <= (len_q < `SBL_LEN_SHORT) ? ST_CHECK : ST_PAY;
               end
            end
            ST_PAY: begin
               if (rx_byte) begin
                  sum_acc_q <= sum_acc_q + rx_data; // RULE3
                  idx_q <= idx_q + 8'h01;
                  if (idx_q + 8'h01 == len_q - 8'h02) begin
                     state_q <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               // Default answer is a lone ACK, then back to idle
               tx_q[0] <= `SBL_ACK; // RULE4
               d2h_data_q <= `SBL_ACK;
               tx_last_q <= 2'd0;
               tx_i_q <= 2'd0;
               next_q <= NX_IDLE;
               state_q <= ST_TX;
               d2h_valid_q <= 1'b1;
               if (!pkt_good) begin
                  // Bad reception touches no command state
                  tx_q[0] <= `SBL_NAK; // RULE4 RULE21
                  d2h_data_q <= `SBL_NAK;
               end else if (cmd == `SBL_CMD_SEND_DATA) begin // RULE12
                  if (dl_open_q && data_len_ok) begin // RULE18
                     status_out <= `SBL_ST_SUCCESS;
                     pidx_q <= 8'h01;
                     next_q <= NX_PROG;
                  end else begin
                     status_out <= `SBL_ST_INVALID_CMD; // RULE5
                  end
               end else if (fixed_len(cmd) == 8'h00) begin
                  status_out <= `SBL_ST_UNKNOWN_CMD; // RULE5
               end else if (!fix_ok) begin
                  status_out <= `SBL_ST_INVALID_CMD; // RULE5
               end else begin
                  case (cmd)
                     `SBL_CMD_PING: begin
                        status_out <= `SBL_ST_SUCCESS; // RULE13
                     end
                     `SBL_CMD_QUERY_RESULT: begin
                        // ACK then the status packet, back to back
                        tx_q[1] <= `SBL_LEN_SHORT; // RULE14
                        tx_q[2] <= status_out;
                        tx_q[3] <= status_out;
                        tx_last_q <= 2'd3;
                        next_q <= NX_RESP;
                     end
                     `SBL_CMD_DOWNLOAD: begin
                        // Hold the ACK until the erase has finished
                        d2h_valid_q <= 1'b0; // RULE17
                        state_q <= ST_ERASE;
                        erase_req_out <= 1'b1;
                        erase_addr_out <= dl_addr;
                        erase_size_out <= dl_size;
                        prog_addr_out <= dl_addr;
                        remain_q <= dl_size;
                        dl_open_q <= 1'b1;
                        status_out <= `SBL_ST_SUCCESS;
                     end
                     `SBL_CMD_RUN: begin
                        run_addr_out <= dl_addr;
                        next_q <= NX_RUN;
                        status_out <= `SBL_ST_SUCCESS;
                     end
                     default: begin
                        next_q <= NX_RESET;
                        status_out <= `SBL_ST_SUCCESS;
                     end
                  endcase
               end
            end
            ST_ERASE: begin
               if (erase_done_in) begin
                  d2h_valid_q <= 1'b1; // RULE17
                  state_q <= ST_TX;
               end
            end
            ST_TX: begin
               if (tx_step) begin
                  if (tx_i_q == tx_last_q) begin
                     d2h_valid_q <= 1'b0;
                     case (next_q)
                        NX_RESP: state_q <= ST_RESP;
                        NX_PROG: state_q <= ST_PROG;
                        NX_RUN, NX_RESET: state_q <= ST_ACT;
                        default: state_q <= ST_IDLE;
                     endcase
                  end else begin
                     // Valid stays high: no gap inside the reply
                     tx_i_q <= tx_i_q + 2'd1; // RULE6 RULE7
                     d2h_data_q <= tx_q[tx_i_q + 2'd1];
                  end
               end
            end
            ST_RESP: begin
               // Either answer ends the exchange; a NAK is
               // followed by the host asking again
               if (rx_byte && rx_data != 8'h00) begin // RULE10
                  state_q <= ST_IDLE;
               end
            end
            ST_PROG: begin
               if (prog_step) begin
                  prog_valid_out <= 1'b0;
                  prog_addr_out <= prog_addr_out + 32'h0000_0001; // RULE18
                  remain_q <= remain_q - 32'h0000_0001;
                  pidx_q <= pidx_q + 8'h01;
               end else if (!prog_valid_out) begin
                  if (prog_end) begin
                     // Bytes past the downloaded count are dropped
                     if (remain_q == '0) begin
                        dl_open_q <= 1'b0; // RULE20
                     end
                     state_q <= ST_IDLE;
                  end else begin
                     prog_valid_out <= 1'b1;
                     prog_data_out <= buf_q[pidx_q[3:0]];
                  end
               end
            end
            ST_ACT: begin
               // The ACK has left before control changes hands
               run_out <= (next_q == NX_RUN); // RULE22
               sw_reset_out <= (next_q == NX_RESET); // RULE23
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule : sbl_device

// *** logic/sbl_fifo.sv ***
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
`timescale 1ns/10ps
module sbl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Full and empty come from the count, never from a guess
   assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // Storage needs no reset; only the pointers and count do
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   // Pointers and fill count
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_q + AW'(push);
         rd_q <= rd_q + AW'(pop);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sbl_fifo

// *** logic/sbl_host.sv ***
/*
 Host controller end: frames one command packet per request, resends on
 NAK, pads with zeros while waiting, and reads back the status packet
 of a status query. Assumes the user raises a request only while ready is high.
*/
`timescale 1ns/10ps
`include "sbl_cfg.svh"
module sbl_host (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   sbl_link_if.host link,
   input wire logic req_valid_in,
   input wire logic [3:0] req_count_in,
   input wire logic [71:0] req_payload_in,
   output logic req_ready_out,
   output logic done_out,
   output sbl_pkg::sbl_byte_t reply_out
);
   typedef enum logic [2:0] {
      HS_IDLE, HS_SEND, HS_WAIT, HS_RLEN, HS_RSUM, HS_RPAY, HS_RACK
   } sbl_host_state_t;

   sbl_host_state_t state_q;
   sbl_pkg::sbl_byte_t tx_q [11];
   sbl_pkg::sbl_byte_t tx_i_q;
   sbl_pkg::sbl_byte_t tx_last_q;
   sbl_pkg::sbl_byte_t rlen_q;
   sbl_pkg::sbl_byte_t rsum_q;
   sbl_pkg::sbl_byte_t racc_q;
   sbl_pkg::sbl_byte_t ridx_q;
   sbl_pkg::sbl_byte_t ans_q;
   logic query_q;
   sbl_pkg::sbl_byte_t h2d_data_q;
   logic h2d_valid_q;

   // Low eight bits of the payload sum
   function automatic sbl_pkg::sbl_byte_t pay_sum(
      input logic [71:0] pay,
      input logic [3:0] n
   );
      pay_sum = 8'h00;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) begin
            pay_sum = pay_sum + pay[8*i +: 8]; // RULE2 RULE3
         end
      end
   endfunction : pay_sum

   wire logic slot = !h2d_valid_q || link.h2d_ready;
   wire logic rx_byte = link.d2h_valid && link.d2h_ready;
   wire logic rx_nz = rx_byte && (link.d2h_data != 8'h00);
   wire logic padding = (state_q == HS_WAIT) || (state_q == HS_RLEN) ||
                        (state_q == HS_RSUM) || (state_q == HS_RPAY);
   wire sbl_pkg::sbl_byte_t req_len = {4'h0, req_count_in} + 8'h02;

   assign link.h2d_valid = h2d_valid_q;
   assign link.h2d_data = h2d_data_q;
   assign link.d2h_ready = 1'b1;

   // Request capture, link sender and reply reader
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_q <= HS_IDLE;
         for (int i = 0; i < 11; i++) begin
            tx_q[i] <= 8'h00;
         end
         tx_i_q <= 8'h00;
         tx_last_q <= 8'h00;
         rlen_q <= 8'h00;
         rsum_q <= 8'h00;
         racc_q <= 8'h00;
         ridx_q <= 8'h00;
         ans_q <= 8'h00;
         query_q <= 1'b0;
         h2d_data_q <= 8'h00;
         h2d_valid_q <= 1'b0;
         req_ready_out <= 1'b0;
         done_out <= 1'b0;
         reply_out <= 8'h00;
      end else begin
         done_out <= 1'b0;
         req_ready_out <= (state_q == HS_IDLE) && !req_valid_in;
         // Zeros keep the link clocked while replies are awaited
         if (slot) begin
            h2d_valid_q <= padding; // RULE11
            h2d_data_q <= 8'h00;
         end
         case (state_q)
            HS_IDLE: begin
               if (req_valid_in && req_ready_out) begin
                  tx_q[0] <= req_len; // RULE1
                  tx_q[1] <= pay_sum(req_payload_in, req_count_in);
                  for (int i = 0; i < 9; i++) begin
                     tx_q[i+2] <= req_payload_in[8*i +: 8]; // RULE12
                  end
                  tx_last_q <= req_len - 8'h01;
                  query_q <= (req_payload_in[7:0] ==
                              `SBL_CMD_QUERY_RESULT); // RULE15
                  tx_i_q <= 8'h00;
                  state_q <= HS_SEND;
               end
            end
            HS_SEND: begin
               if (slot) begin
                  h2d_valid_q <= 1'b1;
                  h2d_data_q <= tx_q[tx_i_q[3:0]];
                  tx_i_q <= tx_i_q + 8'h01;
                  if (tx_i_q == tx_last_q) begin
                     state_q <= HS_WAIT;
                  end
               end
            end
            HS_WAIT: begin
               if (rx_nz) begin
                  if (link.d2h_data == `SBL_NAK) begin
                     tx_i_q <= 8'h00; // RULE9
                     state_q <= HS_SEND;
                  end else if (query_q) begin
                     state_q <= HS_RLEN;
                  end else begin
                     done_out <= 1'b1;
                     state_q <= HS_IDLE;
                  end
               end
            end
            HS_RLEN: begin
               if (rx_nz) begin
                  rlen_q <= link.d2h_data; // RULE6
                  state_q <= HS_RSUM;
               end
            end
            HS_RSUM: begin
               if (rx_byte) begin
                  rsum_q <= link.d2h_data;
                  racc_q <= 8'h00;
                  ridx_q <= 8'h00;
                  state_q <= HS_RPAY;
               end
            end
            HS_RPAY: begin
               if (rx_byte) begin
                  racc_q <= racc_q + link.d2h_data; // RULE3
                  ridx_q <= ridx_q + 8'h01;
                  if (ridx_q == 8'h00) begin
                     reply_out <= link.d2h_data;
                  end
                  if (ridx_q + 8'h03 >= rlen_q) begin
                     ans_q <= (racc_q + link.d2h_data == rsum_q) ?
                              `SBL_ACK : `SBL_NAK; // RULE8
                     state_q <= HS_RACK;
                  end
               end
            end
            HS_RACK: begin
               if (slot) begin
                  h2d_valid_q <= 1'b1;
                  h2d_data_q <= ans_q; // RULE8
                  if (ans_q == `SBL_NAK) begin
                     tx_i_q <= 8'h00; // RULE9
                     state_q <= HS_SEND;
                  end else begin
                     done_out <= 1'b1;
                     state_q <= HS_IDLE;
                  end
               end
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end
endmodule : sbl_host

// *** logic/sbl_link_if.sv ***
/*
 Byte-wide link between the host controller and the boot loader device.
 Assumes both ends run on one clock; each direction is valid/ready.
*/
`timescale 1ns/10ps
interface sbl_link_if (
   input wire logic clk
);
   // Host to device bytes
   sbl_pkg::sbl_byte_t h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   // Device to host bytes
   sbl_pkg::sbl_byte_t d2h_data;
   logic d2h_valid;
   logic d2h_ready;

   modport dev (
      input h2d_data, h2d_valid, d2h_ready,
      output h2d_ready, d2h_data, d2h_valid
   );
   modport host (
      output h2d_data, h2d_valid, d2h_ready,
      input h2d_ready, d2h_data, d2h_valid
   );
endinterface : sbl_link_if

// *** logic/sbl_pkg.sv ***
/*
 Types shared by both ends of the serial boot loader link.
 Assumes sbl_cfg.svh supplies the numeric constants.
*/
package sbl_pkg;
   typedef logic [7:0] sbl_byte_t;
   typedef logic [31:0] sbl_word_t;
endpackage : sbl_pkg

// *** testbench/sbl_link_checker.sv ***
/*
 Checker for the link between the two ends: answer codes, reply framing.
 Assumes one clock and the interface signals handed in as plain inputs.
*/
`timescale 1ns/10ps
module sbl_link_checker (
   input wire logic clk,
   input wire logic sys_rst_in,
   input wire sbl_pkg::sbl_byte_t h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire sbl_pkg::sbl_byte_t d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   // Host byte taken, and the device's reply length byte
   wire tk = h2d_valid && h2d_ready;
   wire rp = d2h_valid && d2h_data == 8'h03;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst_in);
   // Short packets go out back to back, so a fixed window suffices
   property p_ack(l, c);
      tk && h2d_data == l ##1 tk ##1 tk && h2d_data == c
         |-> ##[1:40] d2h_valid && d2h_data == 8'hcc;
   endproperty
   a_answer_code: assert property (d2h_valid |-> d2h_data inside
      {8'hcc, 8'h33, 8'h03, 8'h40, 8'h41, 8'h42})
      else $error("unexpected device byte");
   a_reply_gapless: assert property (rp |=> d2h_valid [*2])
      else $error("gap in reply");
   a_reply_status: assert property (rp |=> d2h_data inside
      {8'h40, 8'h41, 8'h42}) else $error("bad status code");
   a_reply_sum: assert property (rp ##1 d2h_valid |=>
      d2h_data == $past(d2h_data)) else $error("reply sum wrong");
   a_ping_ack: assert property (p_ack(8'h03, 8'h20))
      else $error("ping not acked");
   a_run_ack: assert property (p_ack(8'h07, 8'h22))
      else $error("run not acked");
   a_reset_ack: assert property (p_ack(8'h03, 8'h25))
      else $error("reset not acked");
   a_query_reply: assert property (tk && h2d_data == 8'h03
      ##1 tk ##1 tk && h2d_data == 8'h23 |-> ##[2:40] rp)
      else $error("no query reply");
   a_erase_first: assert property (tk && h2d_data == 8'h0b
      ##1 tk ##1 tk && h2d_data == 8'h21 |-> !d2h_valid [*8]
      ##[1:900] d2h_valid && d2h_data == 8'hcc)
      else $error("download acked early or never");
   cover property (rp);
   cover property (h2d_valid && !h2d_ready);
   cover property (tk && h2d_data == 8'h24);
endmodule : sbl_link_checker

// *** testbench/testbench.sv ***
/*
 Testbench joining host and device ends through the link interface.
 Assumes the flash side is modelled here by erase and ready stimulus.
*/
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic [3:0] req_count = 4'h0;
   logic [71:0] req_payload = '0;
   logic erase_done = 1'b0;
   logic prog_ready = 1'b0;
   logic req_ready, done, erase_req, prog_valid, run_pulse, sw_rst;
   sbl_pkg::sbl_byte_t reply, prog_data, status;
   sbl_pkg::sbl_word_t erase_addr, erase_size, prog_addr, run_addr;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   int runs = 0;
   int rsts = 0;
   logic [39:0] pq[$];

   always #2.5 clk = ~clk;

   sbl_link_if sbl_link_if_i (.clk(clk));
   sbl_host sbl_host_i (.core_clk_in(clk), .sys_rst_in(rst),
      .link(sbl_link_if_i), .req_valid_in(req_valid),
      .req_count_in(req_count), .req_payload_in(req_payload),
      .req_ready_out(req_ready), .done_out(done), .reply_out(reply));
   sbl_device sbl_device_i (.core_clk_in(clk), .sys_rst_in(rst),
      .link(sbl_link_if_i), .erase_req_out(erase_req),
      .erase_addr_out(erase_addr), .erase_size_out(erase_size),
      .erase_done_in(erase_done), .prog_valid_out(prog_valid),
      .prog_addr_out(prog_addr), .prog_data_out(prog_data),
      .prog_ready_in(prog_ready), .run_out(run_pulse),
      .run_addr_out(run_addr), .sw_reset_out(sw_rst),
      .status_out(status));
   sbl_link_checker sbl_link_checker_i (.clk(clk), .sys_rst_in(rst),
      .h2d_data(sbl_link_if_i.h2d_data),
      .h2d_valid(sbl_link_if_i.h2d_valid),
      .h2d_ready(sbl_link_if_i.h2d_ready),
      .d2h_data(sbl_link_if_i.d2h_data),
      .d2h_valid(sbl_link_if_i.d2h_valid),
      .d2h_ready(sbl_link_if_i.d2h_ready));

   // Flash stalls every other cycle to exercise the program handshake
   always @(posedge clk) #1 prog_ready = ~prog_ready;

   // Record flash traffic and pulses; cut a hang short
   always @(posedge clk) begin
      if (prog_valid && prog_ready) pq.push_back({prog_addr, prog_data});
      if (run_pulse === 1'b1) runs++;
      if (sw_rst === 1'b1) rsts++;
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   task chk(input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   // One request, held until taken, then wait for completion
   task send(input logic [3:0] n, input logic [71:0] p);
      while (req_ready !== 1'b1) begin @(posedge clk); #1; end
      req_valid = 1'b1;
      req_count = n;
      req_payload = p;
      @(posedge clk);
      #1 req_valid = 1'b0;
      while (done !== 1'b1) begin @(posedge clk); #1; end
   endtask : send

   task query(input logic [7:0] exp);
      send(4'h1, 72'h23);
      chk(reply, exp);
   endtask : query

   task t_cmds;
      send(4'h1, 72'h30);
      query(8'h41);
      send(4'h2, 72'h20);
      query(8'h42);
      send(4'h1, 72'h20);
      chk(status, 8'h40);
      query(8'h40);
      $display("command test done");
   endtask : t_cmds

   // Erase held off 20 cycles so host padding fills the FIFO
   task t_download;
      fork
         send(4'h9, 72'h03_0000_0000_1000_0021);
         begin
            while (erase_req !== 1'b1) begin @(posedge clk); #1; end
            chk(erase_addr, 32'h0000_1000);
            chk(erase_size, 32'h0000_0003);
            repeat (20) @(posedge clk);
            #1 erase_done = 1'b1;
            @(posedge clk);
            #1 erase_done = 1'b0;
         end
      join
      $display("download test done");
   endtask : t_download

   task t_data;
      send(4'h4, 72'hefcd_ab24);
      repeat (12) @(posedge clk);
      #1 chk(pq.size(), 3);
      chk(pq[0], 40'h00_0010_00ab);
      chk(pq[1], 40'h00_0010_01cd);
      chk(pq[2], 40'h00_0010_02ef);
      send(4'h3, 72'h11_2224);
      repeat (12) @(posedge clk);
      #1 chk(pq.size(), 3);
      query(8'h42);
      $display("data test done");
   endtask : t_data

   task t_jump;
      send(4'h5, 72'h78_5634_1222);
      repeat (4) @(posedge clk);
      #1 chk(runs, 1);
      chk(run_addr, 32'h1234_5678);
      send(4'h1, 72'h25);
      repeat (4) @(posedge clk);
      #1 chk(rsts, 1);
      $display("run and reset test done");
   endtask : t_jump

   task end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // Reset for 8 cycles, then the scenarios in order
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      t_cmds();
      t_download();
      t_data();
      t_jump();
      end_of_test();
   end
endmodule : testbench
